//--- rtl/gpc_pkg.sv
// Purpose: shared constants and types for the pin configuration block, plus its debounce filter
// Assumes: one 50 MHz clock, slow ticks come as one-cycle enables
// Notes:   the filter holds its output until the input has settled for longer than the reject width
`timescale 1ns/1ps
package gpc_pkg;
    localparam int          CLK_HZ          = 50_000_000;
    localparam int          TICK_US         = 100;            // filter sample period
    localparam int          TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int          REJECT_US       = 1000;           // pulses this wide or shorter are dropped
    localparam int          STABLE_TICKS    = REJECT_US / TICK_US + 1;
    localparam int          NUM_PINS        = 14;
    localparam int          NUM_CHANNELS    = 16;
    localparam logic [13:0] INPUT_ALT_MASK  = 14'h0_203;      // steer pins and serial memory data in
    localparam int          STEER_PIN_ZERO  = 0;
    localparam int          STEER_PIN_ONE   = 1;
    localparam logic [7:0]  CFG_RESET       = 8'h01;          // plain non-inverting input

    // per-pin configuration byte, fields from msb down
    typedef struct packed {
        logic [3:0] chan;      // private channel for the steer pins
        logic       alt;       // alternate function select, bit 3
        logic       inten;     // interrupt steering, bit 2
        logic       pol;       // invert, bit 1
        logic       dir;       // 1 input, 0 output, bit 0
    } gpc_cfg_type;

    // host access to configuration and data registers
    typedef struct packed {
        logic       cfg_mode;
        logic       cfg_wr;
        logic       cfg_rd;
        logic [3:0] cfg_sel;
        logic [7:0] cfg_wdata;
        logic       data_wr;
        logic       data_rd;
    } gpc_host_type;
endpackage : gpc_pkg

module gpc_debounce #(
    parameter int STABLE = gpc_pkg::STABLE_TICKS
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // control
    input  wire logic tick,
    input  wire logic enable,
    // level
    input  wire logic level_in,
    output logic      level_out
);
    typedef struct packed {
        logic       held;
        logic [7:0] cnt;
    } gpc_deb_state_type;

    gpc_deb_state_type s_q;
    gpc_deb_state_type s_d;

    // count ticks while input differs; a glitch shorter than the window restarts it
    always_comb begin
        s_d = s_q;
        if (s_q.held == level_in) begin
            s_d.cnt = 8'h00;
        end else if (tick) begin
            if (s_q.cnt >= 8'(STABLE - 1)) begin
                s_d.held = level_in;
                s_d.cnt  = 8'h00;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // filter bypassed when not selected
    assign level_out = enable ? s_q.held : level_in;
endmodule : gpc_debounce

//--- rtl/gpc_port.sv
// Purpose: configuration, pin muxing and interrupt steering for the general purpose pins
// Assumes: host access already decoded into strobes; config mode given by the chip
// Notes:   pin inputs pass two flip-flops before use
`timescale 1ns/1ps
module gpc_port #(
    parameter int NPINS      = gpc_pkg::NUM_PINS,
    parameter int TICK_DIV   = gpc_pkg::TICK_CYCLES,
    parameter int STABLE     = gpc_pkg::STABLE_TICKS
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // host access
    input  gpc_pkg::gpc_host_type     host,
    input  wire logic [NPINS-1:0]     data_wdata,
    output logic      [7:0]           cfg_rdata,
    output logic      [NPINS-1:0]     data_rdata,
    // pins
    input  wire logic [NPINS-1:0]     general_purpose_pin_in,
    output logic      [NPINS-1:0]     general_purpose_pin_out,
    output logic      [NPINS-1:0]     general_purpose_pin_oe,
    // alternate functions
    input  wire logic [NPINS-1:0]     alt_out,
    output logic      [NPINS-1:0]     alt_in,
    // interrupts
    input  wire logic [3:0]           combined_irq_channel_select,
    input  wire logic [2:0]           filter_enable,
    output logic                      combined_pin_interrupt,
    output logic      [15:0]          irq_request
);
    typedef struct packed {
        logic [NPINS-1:0]                         meta;
        logic [NPINS-1:0]                         pin_s;
        logic [NPINS-1:0][7:0]                    cfg;
        logic [NPINS-1:0]                         data;
        logic [NPINS-1:0]                         rdata;
        logic [7:0]                               crdata;
        logic [15:0]                              tick_cnt;
        logic                                     tick;
        logic                                     comb;
        logic [15:0]                              irq;
    } gpc_state_type;

    gpc_state_type    s_q;
    gpc_state_type    s_d;
    logic             rst_meta_q;
    logic             rst_n_q;
    logic [NPINS-1:0] drive_val;
    logic [NPINS-1:0] pin_val;
    logic [NPINS-1:0] sig;
    logic [NPINS-1:0] alt_valid;
    logic             comb_raw;
    logic             comb_f;
    logic [1:0]       ded_raw;
    logic [1:0]       ded_f;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // per pin decode of the low nibble
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        gpc_pkg::gpc_cfg_type c;
        logic                 in_type;
        assign c        = s_q.cfg[i];
        assign in_type  = gpc_pkg::INPUT_ALT_MASK[i];
        // alternate valid only when direction matches its type
        assign alt_valid[i] = c.alt & (in_type ? c.dir : ~c.dir);
        // driven level: alternate output or stored bit, then polarity
        assign drive_val[i] = ((alt_valid[i] & ~in_type) ? alt_out[i] : s_q.data[i]) ^ c.pol;
        assign pin_val[i]   = s_q.pin_s[i] ^ c.pol;
        assign general_purpose_pin_out[i] = drive_val[i];
        assign general_purpose_pin_oe[i]  = ~c.dir;
        // input alternate sees the pin after polarity
        assign alt_in[i] = (alt_valid[i] & in_type) ? pin_val[i] : 1'b0;
        // resulting pin signal, driven or sampled, used for steering
        assign sig[i] = c.dir ? pin_val[i] : drive_val[i];
    end

    // combined request is the OR of steered pins
    always_comb begin
        comb_raw = 1'b0;
        for (int i = 0; i < NPINS; i++) begin
            if (s_q.cfg[i][2]) begin
                comb_raw = comb_raw | sig[i];
            end
        end
    end

    // steer pins with alternate selected form their own paths
    assign ded_raw[0] = alt_valid[gpc_pkg::STEER_PIN_ZERO] & alt_in[gpc_pkg::STEER_PIN_ZERO];
    assign ded_raw[1] = alt_valid[gpc_pkg::STEER_PIN_ONE]  & alt_in[gpc_pkg::STEER_PIN_ONE];

    // three independent filters, one per interrupt path
    gpc_debounce #(.STABLE(STABLE)) u_deb_comb (
        .mclk      (mclk),
        .rst_n     (rst_n_q),
        .tick      (s_q.tick),
        .enable    (filter_enable[0]),
        .level_in  (comb_raw),
        .level_out (comb_f)
    );
    gpc_debounce #(.STABLE(STABLE)) u_deb_d0 (
        .mclk      (mclk),
        .rst_n     (rst_n_q),
        .tick      (s_q.tick),
        .enable    (filter_enable[1]),
        .level_in  (ded_raw[0]),
        .level_out (ded_f[0])
    );
    gpc_debounce #(.STABLE(STABLE)) u_deb_d1 (
        .mclk      (mclk),
        .rst_n     (rst_n_q),
        .tick      (s_q.tick),
        .enable    (filter_enable[2]),
        .level_in  (ded_raw[1]),
        .level_out (ded_f[1])
    );

    // next state: sync, tick divider, host access, interrupt routing
    always_comb begin
        gpc_pkg::gpc_cfg_type c0;
        gpc_pkg::gpc_cfg_type c1;
        s_d = s_q;
        c0  = s_q.cfg[gpc_pkg::STEER_PIN_ZERO];
        c1  = s_q.cfg[gpc_pkg::STEER_PIN_ONE];
        // two-flop synchroniser on the pins
        s_d.meta  = general_purpose_pin_in;
        s_d.pin_s = s_q.meta;
        // slow enable for the filters; one pulse every TICK_DIV mclk cycles
        if (s_q.tick_cnt >= 16'(TICK_DIV - 1)) begin
            s_d.tick_cnt = 16'h0000;
            s_d.tick     = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
            s_d.tick     = 1'b0;
        end
        // configuration registers only in config mode
        if (host.cfg_mode && host.cfg_wr && (32'(host.cfg_sel) < NPINS)) begin
            s_d.cfg[host.cfg_sel] = host.cfg_wdata;
        end
        // a refused read (run mode or no such pin) answers zero rather than stale data
        if (host.cfg_rd) begin
            s_d.crdata = (host.cfg_mode && (32'(host.cfg_sel) < NPINS)) ? s_q.cfg[host.cfg_sel] : 8'h00;
        end
        // data register: outputs take writes, inputs ignore them
        if (!host.cfg_mode && host.data_wr) begin
            for (int i = 0; i < NPINS; i++) begin
                if (!s_q.cfg[i][0]) begin
                    s_d.data[i] = data_wdata[i];
                end
            end
        end
        if (!host.cfg_mode && host.data_rd) begin
            for (int i = 0; i < NPINS; i++) begin
                s_d.rdata[i] = s_q.cfg[i][0] ? pin_val[i] : s_q.data[i];
            end
        end
        // channel routing, channel zero means unrouted
        s_d.comb = comb_f;
        s_d.irq  = 16'h0000;
        if (combined_irq_channel_select != 4'h0) begin
            s_d.irq[combined_irq_channel_select] = comb_f;
        end
        if (c0.chan != 4'h0) begin
            s_d.irq[c0.chan] = s_d.irq[c0.chan] | ded_f[0];
        end
        if (c1.chan != 4'h0) begin
            s_d.irq[c1.chan] = s_d.irq[c1.chan] | ded_f[1];
        end
    end

    // every pin comes up a plain non-inverting input
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q          <= '0;
            s_q.cfg      <= {NPINS{gpc_pkg::CFG_RESET}};
        end else begin
            s_q <= s_d;
        end
    end

    // registered outputs
    assign cfg_rdata              = s_q.crdata;
    assign data_rdata             = s_q.rdata;
    assign combined_pin_interrupt = s_q.comb;
    assign irq_request            = s_q.irq;
endmodule : gpc_port

//--- tb/gpc_pin_model.sv
// Purpose: board side of the pins, switches and pad loop-back
// Assumes: a driven pad reads back its own level
// Notes:   an undriven pad always sees its switch
`timescale 1ns/1ps
module gpc_pin_model (
    // block side
    input  wire logic [13:0] pin_out,
    input  wire logic [13:0] pin_oe,
    // switch levels
    input  wire logic [13:0] sw,
    output logic      [13:0] pin_in
);
    // driver wins where enabled, else the switch
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & sw);
endmodule : gpc_pin_model

//--- tb/gpc_port_monitor.sv
// Purpose: port assertions for the pin block
// Assumes: one clock, active low reset
// Notes:   bound into every gpc_port
`timescale 1ns/1ps
module gpc_port_monitor #(
    parameter int NPINS = 14
) (
    // clock and reset
    input logic                  mclk,
    input logic                  resetn,
    // watched ports
    input gpc_pkg::gpc_host_type host,
    input logic [7:0]            cfg_rdata,
    input logic [NPINS-1:0]      general_purpose_pin_oe,
    input logic [NPINS-1:0]      alt_in,
    input logic [3:0]            combined_irq_channel_select,
    input logic                  combined_pin_interrupt,
    input logic [15:0]           irq_request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // config side, the enable follows the written direction bit
    a_oe_from_dir: assert property (host.cfg_mode && host.cfg_wr && host.cfg_sel < 4'd14
        |=> general_purpose_pin_oe[$past(host.cfg_sel)] == !$past(host.cfg_wdata[0])) else $error("bad oe");
    a_run_wr_ignored: assert property (!host.cfg_mode && host.cfg_wr
        |=> $stable(general_purpose_pin_oe)) else $error("write outside config mode");
    a_rd_refused: assert property (host.cfg_rd && (!host.cfg_mode || host.cfg_sel >= 4'd14)
        |=> cfg_rdata == 8'h00) else $error("refused read not zero");
    a_rdata_holds: assert property (!host.cfg_rd |=> $stable(cfg_rdata)) else $error("read data moved");
    // interrupt side, channel zero means no line
    a_irq0_never: assert property (irq_request[0] == 1'b0) else $error("channel zero raised");
    a_irq_routed: assert property (combined_pin_interrupt && combined_irq_channel_select != 4'h0
        && $stable(combined_irq_channel_select) |-> ##[0:1] irq_request[combined_irq_channel_select])
        else $error("combined request not routed");
    // quiet outputs straight after reset
    a_reset_quiet: assert property ($rose(resetn)
        |-> (general_purpose_pin_oe == '0 && irq_request == 16'h0000) [*3]) else $error("not quiet");
    a_alt_in_valid: assert property (
        (alt_in & (general_purpose_pin_oe | ~gpc_pkg::INPUT_ALT_MASK)) == '0) else $error("bad alt_in");
endmodule : gpc_port_monitor

bind gpc_port gpc_port_monitor #(.NPINS(NPINS)) gpc_port_monitor_i (.mclk, .resetn, .host, .cfg_rdata,
    .general_purpose_pin_oe, .alt_in, .combined_irq_channel_select, .combined_pin_interrupt, .irq_request);

//--- tb/tb.sv
// Purpose: self-checking bench for gpc_port
// Assumes: short filter tick and count, seed 63
// Notes:   random config rounds, then a debounce test
`timescale 1ns/1ps
module tb;
    localparam int TDIV = 4;
    localparam int STB  = 3;
    logic                  mclk, resetn, comb, seen;
    gpc_pkg::gpc_host_type host;
    logic [13:0]           data_wdata, pin_in, pin_out, pin_oe, alt_out, alt_in, data_rdata, sw, dw;
    logic [7:0]            cfg_rdata;
    logic [7:0]            c [14];
    logic [3:0]            cs;
    logic [2:0]            fen;
    logic [15:0]           irq;
    int                    seed = 63;
    int                    n_errors = 0;
    int                    checked = 0;
    int                    cyc = 0;

    gpc_port #(.TICK_DIV(TDIV), .STABLE(STB)) gpc_port_i (.mclk, .resetn, .host, .data_wdata, .cfg_rdata,
        .data_rdata, .general_purpose_pin_in(pin_in), .general_purpose_pin_out(pin_out),
        .general_purpose_pin_oe(pin_oe), .alt_out, .alt_in, .combined_irq_channel_select(cs),
        .filter_enable(fen), .combined_pin_interrupt(comb), .irq_request(irq));
    gpc_pin_model gpc_pin_model_i (.pin_out, .pin_oe, .sw, .pin_in);

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // hang guard, well above the expected run
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    task automatic final_report();
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
        checked = checked + 1;
        if (seen_v !== exp_v) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    // one config strobe for one edge, then an idle edge so calls never re-raise a strobe in one step
    task automatic cfg_acc(input logic wr, input logic [3:0] s, input logic [7:0] d);
        host.cfg_wr    = wr;
        host.cfg_rd    = !wr;
        host.cfg_sel   = s;
        host.cfg_wdata = d;
        step(1);
        host.cfg_wr = 1'b0;
        host.cfg_rd = 1'b0;
        step(1);
    endtask : cfg_acc
    // {alt_in, read, pin_out, irq signal, oe} expected for one pin
    function automatic logic [4:0] expect_pin(input int i);
        logic d, p, o;
        d = c[i][0];
        p = c[i][1];
        o = ((c[i][3] && !gpc_pkg::INPUT_ALT_MASK[i]) ? alt_out[i] : dw[i]) ^ p;
        return {c[i][3] && gpc_pkg::INPUT_ALT_MASK[i] && d && (sw[i] ^ p), d ? sw[i] ^ p : dw[i], o,
                d ? sw[i] ^ p : o, !d};
    endfunction : expect_pin
    task automatic round();
        logic [13:0] eo, er, ea, ee;
        logic [15:0] ei;
        logic        ec, s;
        host.cfg_mode = 1'b1;
        for (int i = 0; i < 14; i++) begin
            c[i] = 8'($random(seed));
            cfg_acc(1'b1, i[3:0], c[i]);
        end
        for (int i = 0; i < 14; i++) begin
            cfg_acc(1'b0, i[3:0], 8'h00);
            chk(cfg_rdata, c[i]);
        end
        host.cfg_mode = 1'b0;
        {sw, alt_out, cs, data_wdata} = 46'({$random(seed), $random(seed)});
        host.data_wr = 1'b1;
        step(1);
        host.data_wr = 1'b0;
        for (int i = 0; i < 14; i++) if (!c[i][0]) dw[i] = data_wdata[i];
        step(6);
        host.data_rd = 1'b1;
        step(1);
        host.data_rd = 1'b0;
        ec = 1'b0;
        ei = 16'h0000;
        for (int i = 0; i < 14; i++) begin
            {ea[i], er[i], eo[i], s, ee[i]} = expect_pin(i);
            ec = ec | (c[i][2] & s);
            if (i < 2 && c[i][3] && c[i][0]) ei[c[i][7:4]] = ei[c[i][7:4]] | (sw[i] ^ c[i][1]);
        end
        ei[cs] = ei[cs] | ec;
        ei[0]  = 1'b0;
        chk(pin_oe, ee);
        chk(pin_out & pin_oe, eo & ee);
        chk(alt_in, ea);
        chk(data_rdata, er);
        chk(comb, ec);
        chk(irq, ei);
    endtask : round

    initial begin
        {resetn, host, data_wdata, sw, alt_out, cs, fen, dw, seen} = '0;
        step(2);
        resetn = 1'b1;
        step(3);
        cfg_acc(1'b1, 4'h3, 8'hf0);
        host.cfg_mode = 1'b1;
        for (int i = 0; i < 16; i++) begin
            cfg_acc(1'b0, i[3:0], 8'h00);
            chk(cfg_rdata, i < 14 ? 8'h01 : 8'h00);
        end
        repeat (20) round();
        // debounce: a short blip dies, a held level passes
        host.cfg_mode = 1'b1;
        for (int i = 0; i < 14; i++) cfg_acc(1'b1, i[3:0], i == 5 ? 8'h05 : (i == 0 ? 8'h39 : 8'h01));
        host.cfg_mode = 1'b0;
        cfg_acc(1'b0, 4'h5, 8'h00);
        chk(cfg_rdata, 8'h00);
        fen = 3'b111;
        cs  = 4'h2;
        sw  = '0;
        step(40);
        sw[5] = 1'b1;
        sw[0] = 1'b1;
        step((STB - 1) * TDIV);
        sw[5] = 1'b0;
        sw[0] = 1'b0;
        repeat (40) begin
            step(1);
            seen = seen | comb | irq[3];
        end
        chk(seen, 1'b0);
        sw[5] = 1'b1;
        sw[0] = 1'b1;
        step((STB + 4) * TDIV);
        chk(comb, 1'b1);
        chk(irq[3], 1'b1);
        chk(irq[2], 1'b1);
        final_report();
    end
endmodule : tb
